// ### src/sfeps_consts.vh
// shared constants of the erase / program / suspend sequencer
`ifndef SFEPS_CONSTS_VH
`define SFEPS_CONSTS_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFEPS_CMD_PARAM_RD 8'h5a
`define SFEPS_CMD_WRITE_ENABLE 8'h06
`define SFEPS_CMD_SECT_ERASE 8'h20
`define SFEPS_CMD_BLK_ERASE 8'hd8
`define SFEPS_CMD_CHIP_ERASE 8'hc7
`define SFEPS_CMD_PAGE_PROG 8'h02
`define SFEPS_CMD_QUAD_PROG 8'h32
`define SFEPS_CMD_SUSPEND 8'hb0
`define SFEPS_CMD_RESUME 8'h30
// ----------------------------------------
// operation kinds
// ----------------------------------------
`define SFEPS_OP_NONE 3'h0
`define SFEPS_OP_SECT 3'h1
`define SFEPS_OP_BLK 3'h2
`define SFEPS_OP_CHIP 3'h3
`define SFEPS_OP_PROG 3'h4
// ----------------------------------------
// address geometry
// ----------------------------------------
`define SFEPS_ADDR_W 22
`define SFEPS_ADDR_MASK 24'h3fffff
`define SFEPS_TOP15 24'h00007f
`define SFEPS_SECT_MASK 24'h000fff
`define SFEPS_BLK8_MASK 24'h001fff
`define SFEPS_BLK32_MASK 24'h007fff
`define SFEPS_BLK64_MASK 24'h00ffff
`define SFEPS_PAGE_MASK 24'h0000ff
`define SFEPS_PAGE_BYTES 9'h100
// ----------------------------------------
// apb register offsets and fields
// ----------------------------------------
`define SFEPS_REG_STATUS 8'h00
`define SFEPS_REG_CONFIG 8'h04
`define SFEPS_REG_PROT_LO 8'h08
`define SFEPS_REG_PROT_HI 8'h0c
`define SFEPS_REG_SUSP_ADDR 8'h10
`define SFEPS_CFG_NIBBLE 0
`define SFEPS_CFG_QUAD_EN 1
`define SFEPS_CFG_RESET 2'h0
`define SFEPS_PROT_RESET 32'h00000000
// ----------------------------------------
// timing
// ----------------------------------------
`define SFEPS_CLK_HZ 10000000
`define SFEPS_SE_TIME_US 1000
`define SFEPS_BE_TIME_US 1000
`define SFEPS_CE_TIME_US 2000
`define SFEPS_PP_TIME_US 500
`define SFEPS_WS_TIME_US 20
`endif

// ### src/sfeps_page_buf.v
// page data buffer: one write port from the link, one read port for the array
`timescale 1ns/1ps
module sfeps_page_buf #(
  parameter DW = 8,
  parameter AW = 8
) (
  // clock
  input wire clk,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // read port, one cycle latency
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1]; // no reset: contents are data only

  // ----------------------------------------
  // ports
  // ----------------------------------------
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // sfeps_page_buf

// ### src/sfeps_sync.v
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module sfeps_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // levels
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r; // first stage, read only by q

  // ----------------------------------------
  // two stages
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sfeps_sync

// ### src/sfeps_top.v
// erase / program / suspend command sequencer of a serial flash, apb status
`timescale 1ns/1ps
`include "sfeps_consts.vh"

module sfeps_top #(
  parameter SE_CYC = `SFEPS_SE_TIME_US * (`SFEPS_CLK_HZ / 1000000),
  parameter BE_CYC = `SFEPS_BE_TIME_US * (`SFEPS_CLK_HZ / 1000000),
  parameter CE_CYC = `SFEPS_CE_TIME_US * (`SFEPS_CLK_HZ / 1000000),
  parameter PP_CYC = `SFEPS_PP_TIME_US * (`SFEPS_CLK_HZ / 1000000),
  parameter [0:0] QUAD_NEEDS_EN = 1'b1
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // serial link pins
  input wire cs_n,
  input wire sck,
  input wire [3:0] sio_in,
  output reg [3:0] sio_out,
  output reg [3:0] sio_oe,
  // parameter table lookup
  output reg [23:0] param_addr,
  input wire [7:0] param_data,
  // flash array control
  output reg arr_start,
  output reg arr_suspend,
  output reg arr_resume,
  output reg arr_done,
  output reg [2:0] arr_kind,
  output reg [23:0] arr_base,
  output reg [23:0] arr_mask,
  output reg [8:0] arr_len,
  // page buffer read for the array
  input wire [7:0] pb_raddr,
  output wire [7:0] pb_rdata
);
  localparam [31:0] WS_CYC = `SFEPS_WS_TIME_US * (`SFEPS_CLK_HZ / 1000000);
  // engine states, one-hot
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_LAT = 3'h4;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // erase mask of the block holding an address: small blocks at both ends
  function [23:0] blk_mask;
    input [23:0] a;
    reg [23:0] hi;
    begin
      hi = (a & `SFEPS_ADDR_MASK) >> 15;
      if (hi == 24'h000000 || hi == `SFEPS_TOP15) begin
        blk_mask = `SFEPS_BLK8_MASK;
      end else if (hi == 24'h000001 || hi == `SFEPS_TOP15 - 24'h000001) begin
        blk_mask = `SFEPS_BLK32_MASK;
      end else begin
        blk_mask = `SFEPS_BLK64_MASK;
      end
    end
  endfunction

  // two addresses fall in the same region of the given mask
  function same_reg;
    input [23:0] a;
    input [23:0] b;
    input [23:0] m;
    begin
      same_reg = (((a ^ b) & ~m & `SFEPS_ADDR_MASK) == 24'h000000);
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  wire [5:0] pin_s; // {cs_n, sck, sio}
  reg cs_d_r; // previous synced chip select
  reg sck_d_r; // previous synced clock
  sfeps_sync #(.W(6), .RST_VAL(6'h20)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({cs_n, sck, sio_in}),
    .q(pin_s)
  );
  wire cs_s = pin_s[5];
  wire sck_s = pin_s[4];
  wire [3:0] sio_s = pin_s[3:0];

  // edge history on synced levels only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cs_d_r <= cs_s;
      sck_d_r <= sck_s;
    end
  end
  wire frame_go = cs_d_r & ~cs_s; // frame opens
  wire frame_end = ~cs_d_r & cs_s; // frame closes: commands act here
  wire sck_rise = ~cs_s & ~sck_d_r & sck_s;
  wire sck_fall = ~cs_s & sck_d_r & ~sck_s;

  // ----------------------------------------
  // registers and engine state
  // ----------------------------------------
  reg [1:0] cfg_r; // nibble-wide protocol, quad enable
  reg [31:0] prot_lo_r; // one bit per 64k region, low half
  reg [31:0] prot_hi_r; // high half
  reg [2:0] st_r; // engine state
  reg [31:0] cnt_r; // cycles left in run or latency
  reg [2:0] kind_r; // running operation
  reg wel_r; // write-enable latch
  reg esus_r; // erase_suspended_flag
  reg psus_r; // program_suspended_flag
  reg [2:0] sv_kind_r; // suspended operation
  reg [23:0] sv_base_r;
  reg [23:0] sv_mask_r;
  reg [8:0] sv_len_r;
  reg [31:0] sv_cnt_r; // its remaining time
  wire busy = ~st_r[0];
  wire [63:0] prot = {prot_hi_r, prot_lo_r};

  // ----------------------------------------
  // link receiver
  // ----------------------------------------
  reg [7:0] op_r; // opcode of the frame
  reg [7:0] sh_r; // input shifter
  reg [2:0] bit_cnt_r; // bits of the current byte
  reg [2:0] byte_cnt_r; // whole bytes, saturates at 7
  reg [23:0] addr_r; // received address
  reg [7:0] col_r; // column of the next data byte
  reg [8:0] dcnt_r; // data bytes kept, at most a page
  wire is_prog = (op_r == `SFEPS_CMD_PAGE_PROG) | (op_r == `SFEPS_CMD_QUAD_PROG);
  // quad program: opcode on one line, the rest on four
  wire wide = cfg_r[`SFEPS_CFG_NIBBLE] |
              ((op_r == `SFEPS_CMD_QUAD_PROG) & (byte_cnt_r != 3'h0));
  wire [7:0] sh_nxt = wide ? {sh_r[3:0], sio_s} : {sh_r[6:0], sio_s[0]};
  wire [2:0] bit_nxt = bit_cnt_r + (wide ? 3'h4 : 3'h1);
  wire byte_done = sck_rise & (bit_nxt == 3'h0);
  // buffer is frozen while busy or while a program waits suspended
  wire pb_we = byte_done & is_prog & (byte_cnt_r >= 3'h4) & ~busy & ~psus_r;

  // assemble opcode, address and data bytes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= 8'h00;
      sh_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      addr_r <= 24'h000000;
      col_r <= 8'h00;
      dcnt_r <= 9'h000;
    end else if (frame_go) begin
      op_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      dcnt_r <= 9'h000;
    end else if (sck_rise) begin
      sh_r <= sh_nxt;
      bit_cnt_r <= bit_nxt;
      if (bit_nxt == 3'h0) begin
        if (byte_cnt_r != 3'h7) begin
          byte_cnt_r <= byte_cnt_r + 3'h1;
        end
        case (byte_cnt_r)
          3'h0: op_r <= sh_nxt;
          3'h1: addr_r[23:16] <= sh_nxt;
          3'h2: addr_r[15:8] <= sh_nxt;
          3'h3: begin
            addr_r[7:0] <= sh_nxt;
            col_r <= sh_nxt;
          end
          default: begin
            // data: column wraps within the page, ring keeps the newest
            if (is_prog) begin
              col_r <= col_r + 8'h01;
              if (dcnt_r != `SFEPS_PAGE_BYTES) begin
                dcnt_r <= dcnt_r + 9'h001;
              end
            end
          end
        endcase
      end
    end
  end

  sfeps_page_buf #(.DW(8), .AW(8)) u_buf (
    .clk(pclk),
    .we(pb_we),
    .waddr(col_r),
    .wdata(sh_nxt),
    .raddr(pb_raddr),
    .rdata(pb_rdata)
  );

  // ----------------------------------------
  // parameter read output
  // ----------------------------------------
  reg [7:0] osh_r; // output shifter
  reg [2:0] obit_r; // bits left of the current byte
  wire rd_phase = (op_r == `SFEPS_CMD_PARAM_RD) & (byte_cnt_r >= 3'h5);

  // data leaves on falling sck after address and dummy byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sio_out <= 4'h0;
      sio_oe <= 4'h0;
      osh_r <= 8'h00;
      obit_r <= 3'h0;
      param_addr <= 24'h000000;
    end else if (frame_go | frame_end) begin
      sio_oe <= 4'h0;
      obit_r <= 3'h0;
    end else if (byte_done & (byte_cnt_r == 3'h3)) begin
      param_addr <= {addr_r[23:8], sh_nxt};
    end else if (sck_fall & rd_phase) begin
      sio_oe[1] <= 1'b1;
      if (obit_r == 3'h0) begin
        sio_out[1] <= param_data[7];
        osh_r <= {param_data[6:0], 1'b0};
        obit_r <= 3'h7;
        param_addr <= param_addr + 24'h000001;
      end else begin
        sio_out[1] <= osh_r[7];
        osh_r <= {osh_r[6:0], 1'b0};
        obit_r <= obit_r - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // command decode at frame end
  // ----------------------------------------
  reg acc; // write operation may start
  reg [2:0] acc_kind;
  reg [23:0] acc_mask;
  reg [31:0] acc_cyc;
  reg do_wel; // latch set
  reg do_sus; // suspend taken
  reg do_res; // resume taken
  wire cmd_only = (byte_cnt_r == 3'h1) & (bit_cnt_r == 3'h0);
  wire addr_only = (byte_cnt_r == 3'h4) & (bit_cnt_r == 3'h0);
  wire [23:0] bmask = blk_mask(addr_r);
  wire hit_prot = prot[addr_r[`SFEPS_ADDR_W-1:16]];
  wire quad_ok = ~QUAD_NEEDS_EN | cfg_r[`SFEPS_CFG_QUAD_EN];

  always @* begin
    acc = 1'b0;
    acc_kind = `SFEPS_OP_NONE;
    acc_mask = 24'h000000;
    acc_cyc = 32'h00000000;
    do_wel = 1'b0;
    do_sus = 1'b0;
    do_res = 1'b0;
    if (frame_end) begin
      case (op_r)
        `SFEPS_CMD_WRITE_ENABLE: do_wel = cmd_only & ~busy;
        `SFEPS_CMD_SECT_ERASE: begin
          acc_kind = `SFEPS_OP_SECT;
          acc_mask = `SFEPS_SECT_MASK;
          acc_cyc = SE_CYC;
          // no erase over a suspended page or during an erase suspend
          acc = addr_only & ~hit_prot & ~esus_r &
                ~(psus_r & same_reg(sv_base_r, addr_r, `SFEPS_SECT_MASK));
        end
        `SFEPS_CMD_BLK_ERASE: begin
          acc_kind = `SFEPS_OP_BLK;
          acc_mask = bmask;
          acc_cyc = BE_CYC;
          acc = addr_only & ~hit_prot & ~esus_r &
                ~(psus_r & same_reg(sv_base_r, addr_r, bmask));
        end
        `SFEPS_CMD_CHIP_ERASE: begin
          acc_kind = `SFEPS_OP_CHIP;
          acc_mask = `SFEPS_ADDR_MASK;
          acc_cyc = CE_CYC;
          acc = cmd_only & (prot == 64'h0) & ~esus_r & ~psus_r;
        end
        `SFEPS_CMD_PAGE_PROG, `SFEPS_CMD_QUAD_PROG: begin
          acc_kind = `SFEPS_OP_PROG;
          acc_mask = `SFEPS_PAGE_MASK;
          acc_cyc = PP_CYC;
          // a trailing partial byte is simply not counted
          acc = (dcnt_r != 9'h000) & ~hit_prot & ~psus_r &
                ~(esus_r & same_reg(sv_base_r, addr_r, sv_mask_r)) &
                ((op_r == `SFEPS_CMD_PAGE_PROG) | quad_ok);
        end
        `SFEPS_CMD_SUSPEND: begin
          do_sus = cmd_only & st_r[1] & (kind_r != `SFEPS_OP_CHIP) &
                   ~esus_r & ~psus_r;
        end
        `SFEPS_CMD_RESUME: begin
          do_res = cmd_only & ~busy & (esus_r | psus_r);
        end
        default: acc = 1'b0;
      endcase
    end
  end
  wire go = acc & wel_r & ~busy;

  // ----------------------------------------
  // self-timed operation engine
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 32'h00000000;
      kind_r <= `SFEPS_OP_NONE;
      wel_r <= 1'b0;
      esus_r <= 1'b0;
      psus_r <= 1'b0;
      sv_kind_r <= `SFEPS_OP_NONE;
      sv_base_r <= 24'h000000;
      sv_mask_r <= 24'h000000;
      sv_len_r <= 9'h000;
      sv_cnt_r <= 32'h00000000;
      arr_start <= 1'b0;
      arr_suspend <= 1'b0;
      arr_resume <= 1'b0;
      arr_done <= 1'b0;
      arr_kind <= `SFEPS_OP_NONE;
      arr_base <= 24'h000000;
      arr_mask <= 24'h000000;
      arr_len <= 9'h000;
    end else begin
      arr_start <= 1'b0;
      arr_suspend <= 1'b0;
      arr_resume <= 1'b0;
      arr_done <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (do_wel) begin
            wel_r <= 1'b1;
          end else if (go) begin
            // start: busy until the count runs out
            st_r <= ST_RUN;
            cnt_r <= acc_cyc;
            kind_r <= acc_kind;
            arr_start <= 1'b1;
            arr_kind <= acc_kind;
            arr_base <= addr_r & ~acc_mask & `SFEPS_ADDR_MASK;
            arr_mask <= acc_mask;
            arr_len <= (acc_kind == `SFEPS_OP_PROG) ? dcnt_r : 9'h000;
          end else if (do_res) begin
            // restart the held operation with the time it had left
            st_r <= ST_RUN;
            cnt_r <= sv_cnt_r;
            kind_r <= sv_kind_r;
            arr_kind <= sv_kind_r;
            arr_base <= sv_base_r;
            arr_mask <= sv_mask_r;
            arr_len <= sv_len_r;
            esus_r <= 1'b0;
            psus_r <= 1'b0;
            arr_resume <= 1'b1;
          end
        end
        ST_RUN: begin
          if (do_sus) begin
            sv_kind_r <= kind_r;
            sv_base_r <= arr_base;
            sv_mask_r <= arr_mask;
            sv_len_r <= arr_len;
            sv_cnt_r <= cnt_r;
            esus_r <= (kind_r != `SFEPS_OP_PROG);
            psus_r <= (kind_r == `SFEPS_OP_PROG);
            kind_r <= `SFEPS_OP_NONE;
            cnt_r <= WS_CYC;
            st_r <= ST_LAT;
            arr_suspend <= 1'b1;
          end else if (cnt_r <= 32'h00000001) begin
            st_r <= ST_IDLE;
            kind_r <= `SFEPS_OP_NONE;
            wel_r <= 1'b0;
            arr_done <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 32'h00000001;
          end
        end
        ST_LAT: begin
          // busy, deaf to commands, until the suspend settles
          if (cnt_r <= 32'h00000001) begin
            st_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 32'h00000001;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  wire map_hit = (paddr == `SFEPS_REG_STATUS) | (paddr == `SFEPS_REG_CONFIG) |
                 (paddr == `SFEPS_REG_PROT_LO) | (paddr == `SFEPS_REG_PROT_HI) |
                 (paddr == `SFEPS_REG_SUSP_ADDR);
  wire apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~map_hit; // unmapped offsets answer error

  // read data captured in the setup cycle, so it is a flop at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `SFEPS_REG_STATUS: prdata <= {25'h0, kind_r, psus_r, esus_r, wel_r, busy};
        `SFEPS_REG_CONFIG: prdata <= {30'h0, cfg_r};
        `SFEPS_REG_PROT_LO: prdata <= prot_lo_r;
        `SFEPS_REG_PROT_HI: prdata <= prot_hi_r;
        `SFEPS_REG_SUSP_ADDR: prdata <= {8'h00, sv_base_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // writable registers; a write to a read-only offset is dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `SFEPS_CFG_RESET;
      prot_lo_r <= `SFEPS_PROT_RESET;
      prot_hi_r <= `SFEPS_PROT_RESET;
    end else if (apb_wr) begin
      case (paddr)
        `SFEPS_REG_CONFIG: cfg_r <= pwdata[1:0];
        `SFEPS_REG_PROT_LO: prot_lo_r <= pwdata;
        `SFEPS_REG_PROT_HI: prot_hi_r <= pwdata;
        default: cfg_r <= cfg_r;
      endcase
    end
  end
endmodule // sfeps_top

// ### test/sfeps_chk_asserts.sv
// checker of the sequencer's apb and array-control ports
`timescale 1ns/1ps
module sfeps_chk #(
  parameter int BE_CYC = 50,
  parameter int PP_CYC = 50
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb side
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pslverr,
  // array control
  input wire arr_start,
  input wire arr_suspend,
  input wire arr_resume,
  input wire arr_done,
  input wire [2:0] arr_kind,
  input wire [23:0] arr_base,
  input wire [8:0] arr_len
);
  // ----------------------------------------
  // timing windows, a little slack for the engine's own edge
  // ----------------------------------------
  localparam int BE_LO = BE_CYC - 2;
  localparam int BE_HI = BE_CYC + 3;
  localparam int PP_LO = PP_CYC - 2;
  localparam int PP_HI = PP_CYC + 3;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_sect_align: assert property (arr_start && arr_kind == 3'h1 |-> arr_base[11:0] == 12'h0)
    else $error("sector base not aligned");
  a_blk_align: assert property (arr_start && arr_kind == 3'h2 |-> arr_base[12:0] == 13'h0)
    else $error("block base not aligned");
  a_len_range: assert property (arr_start && arr_kind == 3'h4 |-> arr_len inside {[1:256]})
    else $error("program length out of range");
  a_blk_time: assert property (arr_start && arr_kind == 3'h2 |-> ##[BE_LO:BE_HI] arr_done)
    else $error("block erase time wrong");
  a_prog_time: assert property (arr_start && arr_kind == 3'h4 |-> ##[PP_LO:PP_HI] arr_done)
    else $error("program time wrong");
  a_no_chip_susp: assert property (arr_suspend |-> arr_kind != 3'h3)
    else $error("chip erase suspended");
  a_susp_quiet: assert property (arr_suspend |=> (!arr_start && !arr_resume)[*8])
    else $error("command taken during suspend latency");
  a_resume_kind: assert property (arr_resume |-> arr_kind inside {3'h1, 3'h2, 3'h4})
    else $error("resume of no valid operation");
  a_err_unmap: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not flagged");
  a_no_double: assert property (arr_start |=> !arr_start && !$rose(arr_done))
    else $error("start pulse malformed");
  c_blk: cover property (arr_start && arr_kind == 3'h2);
  c_susp: cover property (arr_suspend);
  c_res: cover property (arr_resume);
endmodule // sfeps_chk
bind sfeps_top sfeps_chk #(.BE_CYC(BE_CYC), .PP_CYC(PP_CYC)) i_sfeps_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .arr_start(arr_start), .arr_suspend(arr_suspend), .arr_resume(arr_resume),
  .arr_done(arr_done), .arr_kind(arr_kind), .arr_base(arr_base), .arr_len(arr_len));

// ### test/sfeps_host_model.sv
// host controller model: frames commands on the serial link
`timescale 1ns/1ps
module sfeps_host_model (
  // link pins
  output reg cs_n,
  output reg sck,
  output reg [3:0] sio,
  // return line, low unless the device drives it
  input wire so
);
  reg [7:0] r; // last eight bits seen on the return line at sck rise
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sio = 4'ha;
  end
  // one byte as bits or nibbles, mode 0: data set while sck low, 800 ns period
  task put(input [7:0] b, input qd);
    integer i;
    for (i = 0; i < (qd ? 2 : 8); i = i + 1) begin
      if (qd) sio = b[7 - 4 * i -: 4];
      else sio[0] = b[7 - i];
      #400 sck = 1'b1;
      r = {r[6:0], so};
      #400 sck = 0;
    end
  endtask
  // opcode always serial, then address, data and a trailing part byte
  task frame(input [7:0] op, input integer na, input [23:0] a, input integer nd,
    input [7:0] sd, input integer tl, input qd);
    integer k;
    #37 cs_n = 1'b0;
    #400 put(op, 1'b0);
    for (k = 0; k < na; k = k + 1) put(a[23 - 8 * k -: 8], qd);
    for (k = 0; k < nd; k = k + 1) put(sd + k[7:0], qd);
    for (k = 0; k < tl; k = k + 1) begin
      sio[0] = $urandom;
      #400 sck = 1'b1;
      #400 sck = 0;
    end
    #400 cs_n = 1'b1;
    // released lines must not keep their last value
    sio = ~sio;
    #1000;
  endtask
endmodule // sfeps_host_model

// ### test/tb.sv
// self-checking bench of the erase / program / suspend sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: %h vs %h", $time, a, b); end end
module tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [7:0] paddr = 0, pbr = 0;
  reg [31:0] pwdata = 0, rd;
  reg er;
  wire [31:0] prdata;
  wire pready, pslverr, cs_n, sck, st, su, re;
  wire [3:0] sio;
  wire [2:0] k;
  wire [23:0] ab, am, pa;
  wire [3:0] sout, soe;
  wire [8:0] ln;
  wire [7:0] pbd;
  integer miscompares = 0, cmp_count = 0, cyc = 0, i;
  reg [37:0] q[$], ob, ev;
  reg [23:0] a;
  reg [23:0] bt[3] = '{24'h003456, 24'h00c123, 24'h123456};
  reg [23:0] bb[3] = '{24'h003fff, 24'h00ffff, 24'h12ffff};
  always #50 pclk = ~pclk;
  sfeps_top #(.SE_CYC(2000), .BE_CYC(50), .CE_CYC(50), .PP_CYC(50)) i_sfeps_top (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n),
    .sck(sck), .sio_in(sio), .sio_out(sout), .sio_oe(soe), .param_addr(pa),
    .param_data(pa[7:0] + 8'h11),
    .arr_start(st), .arr_suspend(su), .arr_resume(re), .arr_done(), .arr_kind(k),
    .arr_base(ab), .arr_mask(am), .arr_len(ln), .pb_raddr(pbr), .pb_rdata(pbd));
  sfeps_host_model i_sfeps_host_model (.cs_n(cs_n), .sck(sck), .sio(sio),
    .so(sout[1] & soe[1]));
  // ----------------------------------------
  // closing report and hang guard
  // ----------------------------------------
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      miscompares++;
      print_verdict;
    end
  end
  // ----------------------------------------
  // bus and link helpers
  // ----------------------------------------
  task apb(input w, input [7:0] ad, input [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rdchk(input [7:0] ad, input [31:0] e);
    apb(0, ad, 0);
    `CHK(rd, e)
  endtask
  task ex(input [1:0] e, input [2:0] kk, input [23:0] b, input [8:0] l);
    q.push_back({e, kk, b, l});
  endtask
  task run(input [7:0] op, input integer na, input [23:0] ad, input integer nd,
    input integer tl, input qd);
    i_sfeps_host_model.frame(op, na, ad, nd, 8'h10, tl, qd);
    repeat (10) @(posedge pclk);
  endtask
  task write_enable_command;
    run(8'h06, 0, 0, 0, 0, 0);
  endtask
  // poll busy until the self-timed work ends
  task idle;
    do apb(0, 8'h00, 0); while (rd[0] !== 1'b0);
  endtask
  // ----------------------------------------
  // monitor: every array start, suspend and resume must match the oldest note
  // ----------------------------------------
  // sampled mid-cycle, where the registered pulses are settled
  always @(negedge pclk) if (st | su | re) begin
    ob = {su ? 2'd1 : re ? 2'd2 : 2'd0, k, (st && (k == 1 || k == 2)) ? ab | am : 24'h0,
      (st && k == 4) ? ln : 9'h0};
    ev = q.size() ? q.pop_front() : 38'h0;
    `CHK(ob, ev)
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1c90));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    rdchk(8'h04, 0);
    rdchk(8'h08, 0);
    apb(0, 8'h20, 0);
    `CHK({er, rd}, 33'h100000000)
    apb(1, 8'h00, 32'hff);
    rdchk(8'h00, 0);
    // second table byte after the dummy: address a7h plus one
    run(8'h5a, 3, 24'h0000a7, 3, 0, 0);
    `CHK(i_sfeps_host_model.r, 8'hb9)
    $display("test registers done");
    a = $urandom & 24'h3fffff;
    run(8'h20, 3, a, 0, 0, 0);
    write_enable_command;
    ex(0, 1, a & 24'h3ff000 | 24'h000fff, 0);
    run(8'h20, 3, a, 0, 0, 0);
    idle;
    rdchk(8'h00, 0);
    for (i = 0; i < 3; i++) begin
      write_enable_command;
      ex(0, 2, bb[i], 0);
      run(8'hd8, 3, bt[i], 0, 0, 0);
      idle;
    end
    apb(1, 8'h08, 32'h40000);
    write_enable_command;
    run(8'hd8, 3, 24'h123456, 0, 0, 0);
    run(8'hc7, 0, 0, 0, 0, 0);
    apb(1, 8'h08, 0);
    ex(0, 3, 0, 0);
    run(8'hc7, 0, 0, 0, 0, 0);
    idle;
    $display("test erase done");
    write_enable_command;
    run(8'h32, 3, 24'h0100f0, 2, 0, 1);
    apb(1, 8'h04, 32'h2);
    for (i = 0; i < 4; i++) begin
      write_enable_command;
      ex(0, 4, 0, i == 1 ? 256 : i == 0 ? 3 : 2);
      run(i == 3 ? 8'h32 : 8'h02, 3, 24'h0100f0, i == 1 ? 300 : i == 0 ? 3 : 2,
        i == 2 ? 4 : 0, i == 3);
      idle;
      if (i == 1) begin
        pbr <= 8'h01;
        repeat (3) @(posedge pclk);
        `CHK(pbd, 8'h21)
      end
    end
    $display("test program done");
    write_enable_command;
    ex(0, 1, 24'h201fff, 0);
    run(8'h20, 3, 24'h201234, 0, 0, 0);
    ex(1, 1, 0, 0);
    run(8'hb0, 0, 0, 0, 0, 0);
    repeat (300) @(posedge pclk);
    apb(0, 8'h00, 0);
    `CHK(rd[2], 1'b1)
    repeat (5000) @(posedge pclk);
    run(8'hb0, 0, 0, 0, 0, 0);
    write_enable_command;
    run(8'hc7, 0, 0, 0, 0, 0);
    ex(2, 1, 0, 0);
    run(8'h30, 0, 0, 0, 0, 0);
    apb(0, 8'h00, 0);
    `CHK(rd[2], 1'b0)
    idle;
    $display("test suspend done");
    `CHK(q.size(), 0)
    print_verdict;
  end
endmodule // tb
